// ==== hw/cfm_pkg.sv ====
/*
 package of the channel fault and restart manager: offsets, fields, resets, timing.
 assumes a 250 MHz mclk and a 1 us tick made from it.
*/
package cfm_pkg;
	localparam int NCH = 8;
	localparam int DAC_BITS = 10;
	localparam int CLK_NS = 4;
	localparam int TICK_NS = 1000;
	localparam logic [7:0] TICK_CYC = 8'(TICK_NS / CLK_NS);
	localparam int DEGLITCH_US = 10;
	localparam logic [15:0] DEGLITCH_TICKS = 16'(DEGLITCH_US * 1000 / TICK_NS);
	localparam int RESET_PULSE_MIN_US = 10;
	localparam logic [15:0] RESET_PULSE_TICKS = 16'(RESET_PULSE_MIN_US * 1000 / TICK_NS);
	localparam logic [3:0] ADC_VIN_CH = 4'h8;
	// register offsets
	localparam logic [7:0] REG_OPERATION = 8'h00;
	localparam logic [7:0] REG_CLEAR_FAULTS = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_STATE = 8'h0c;
	localparam logic [7:0] REG_CUT_OV = 8'h10;
	localparam logic [7:0] REG_CUT_UV = 8'h14;
	localparam logic [7:0] REG_PG_MAP = 8'h18;
	localparam logic [7:0] REG_DEVICE_CFG = 8'h1c;
	localparam logic [7:0] REG_RESTART_DLY = 8'h20;
	localparam logic [7:0] REG_RETRY_DLY = 8'h24;
	localparam logic [7:0] REG_PERSIST = 8'h28;
	localparam logic [7:0] REG_VIN_LIMITS = 8'h2c;
	localparam logic [1:0] REG_CH_WINDOW = 2'h1;
	localparam logic [1:0] REG_CH_CFG = 2'h0;
	localparam logic [1:0] REG_CH_TON = 2'h1;
	localparam logic [1:0] REG_CH_WARN = 2'h2;
	// channel_config_word fields and the device config share bit
	localparam int CFG_POL = 0;
	localparam int CFG_RANGE = 1;
	localparam int CFG_CTRL = 2;
	localparam int CFG_OVR = 3;
	localparam int CFG_UVR = 5;
	localparam int CFG_RETRY = 7;
	localparam int CFG_FWD = 8;
	localparam int CFG_LSN = 12;
	localparam int CFG_CODE = 16;
	localparam int DEV_SHARE = 0;
	// reset values
	localparam logic [7:0] OPER_RST = 8'hff;
	localparam logic [31:0] CFG_RST = 32'h0000_0028;
	localparam logic [15:0] TON_RST = 16'h000a;
	localparam logic [31:0] WARN_RST = 32'h0000_ffff;
	localparam logic [15:0] RESTART_RST = 16'h03e8;
	localparam logic [15:0] RETRY_RST = 16'h03e8;
	localparam logic [15:0] PERSIST_RST = 16'h0064;
	localparam logic [31:0] VIN_LIM_RST = 32'h0000_0000;
	localparam logic [7:0] PG_MAP_RST = 8'hff;
	typedef enum logic [1:0] {
		RESP_IGNORE = 2'b00,
		RESP_NOW = 2'b01,
		RESP_LATER = 2'b10,
		RESP_SPARE = 2'b11
	} cfm_resp_e;
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_TON = 3'b001,
		ST_ON = 3'b010,
		ST_RETRY = 3'b011,
		ST_LATCH = 3'b100,
		ST_ZONE = 3'b101,
		ST_HOLD = 3'b110
	} cfm_state_e;
endpackage : cfm_pkg

// ==== hw/cfm_deglitch.sv ====
/*
 low-level qualifier: flags a line that has stayed low for TICKS ticks.
 assumes a one-cycle tick enable and inputs synchronous to mclk.
*/
`timescale 1ns/1ps
module cfm_deglitch #(
	parameter logic [15:0] TICKS = 16'h000a
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic lowIn,
	output logic qualLow
);
	import cfm_pkg::*;
	logic [15:0] cnt_ff;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 16'h0000;
			qualLow <= 1'b0;
		end else if (!lowIn) begin
			cnt_ff <= 16'h0000;
			qualLow <= 1'b0;
		end else begin
			if (tick && cnt_ff != TICKS)
				cnt_ff <= cnt_ff + 16'h0001;
			qualLow <= (cnt_ff == TICKS);
		end
	end
endmodule : cfm_deglitch

// ==== hw/cfm_chan_seq.sv ====
/*
 one channel's on/off, fault, retry, latch, zone and restart sequencer.
 assumes a 1 us tick; delays are counted in ticks.
*/
`timescale 1ns/1ps
module cfm_chan_seq (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic softRst,
	input wire logic tick,
	input wire logic runReq,
	input wire logic restartReq,
	input wire logic clearLatch,
	input wire logic faultNow,
	input wire logic faultLater,
	input wire logic zoneOff,
	input wire logic retryEn,
	input wire logic [15:0] tonDelay,
	input wire logic [15:0] retryDelay,
	input wire logic [15:0] restartDelay,
	input wire logic [15:0] persist,
	output logic convEn,
	output logic faultedOff,
	output logic latched
);
	import cfm_pkg::*;
	cfm_state_e st_ff, nxt_st;
	logic [15:0] cnt_ff, pcnt_ff, lim;
	logic done, trip;
	// persistence count for deferred faults
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			pcnt_ff <= 16'h0000;
		else if (softRst || !faultLater)
			pcnt_ff <= 16'h0000;
		else if (tick && pcnt_ff != 16'hffff)
			pcnt_ff <= pcnt_ff + 16'h0001;
	end
	assign trip = faultNow || (faultLater && pcnt_ff >= persist);
	always_comb begin
		case (st_ff)
			ST_TON: lim = tonDelay;
			ST_RETRY: lim = retryDelay;
			ST_HOLD: lim = restartDelay;
			default: lim = 16'h0000;
		endcase
		done = (cnt_ff >= lim);
		nxt_st = st_ff;
		case (st_ff)
			ST_OFF: begin
				if (restartReq)
					nxt_st = ST_HOLD;
				else if (runReq && !zoneOff)
					nxt_st = ST_TON;
			end
			ST_TON: begin
				if (!runReq || zoneOff)
					nxt_st = ST_OFF;
				else if (restartReq)
					nxt_st = ST_HOLD;
				else if (done)
					nxt_st = ST_ON;
			end
			ST_ON: begin
				if (trip)
					nxt_st = retryEn ? ST_RETRY : ST_LATCH;
				else if (zoneOff)
					nxt_st = ST_ZONE;
				else if (!runReq)
					nxt_st = ST_OFF;
				else if (restartReq)
					nxt_st = ST_HOLD;
			end
			ST_RETRY: if (done) nxt_st = ST_OFF;
			ST_LATCH: if (clearLatch) nxt_st = ST_OFF;
			ST_ZONE: if (!zoneOff) nxt_st = ST_OFF;
			ST_HOLD: if (done) nxt_st = ST_OFF;
			default: nxt_st = ST_OFF;
		endcase
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= ST_OFF;
			cnt_ff <= 16'h0000;
			convEn <= 1'b0;
			faultedOff <= 1'b0;
			latched <= 1'b0;
		end else if (softRst) begin
			st_ff <= ST_OFF;
			cnt_ff <= 16'h0000;
			convEn <= 1'b0;
			faultedOff <= 1'b0;
			latched <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (nxt_st != st_ff)
				cnt_ff <= 16'h0000;
			else if (tick && !done)
				cnt_ff <= cnt_ff + 16'h0001;
			convEn <= (nxt_st == ST_ON);
			faultedOff <= (nxt_st == ST_RETRY) || (nxt_st == ST_LATCH);
			latched <= (nxt_st == ST_LATCH);
		end
	end
endmodule : cfm_chan_seq

// ==== hw/cfm_fault_restart.sv ====
/*
 eight-channel fault and restart manager: apb registers, status and alert,
 input cut-off, four fault zone lines, power good, control restart, reset input.
 assumes an apb master on mclk, comparator fault levels and adc samples as inputs.
*/
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module cfm_fault_restart (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] controlIn,
	input wire logic watchdogResetIn,
	input wire logic [cfm_pkg::NCH-1:0] ovFaultIn,
	input wire logic [cfm_pkg::NCH-1:0] uvFaultIn,
	input wire logic adcValid,
	input wire logic [3:0] adcChan,
	input wire logic [15:0] adcData,
	input wire logic shareClkIn,
	input wire logic [3:0] zoneFaultLineIn,
	output logic [3:0] zoneFaultLineOut,
	output logic [3:0] zoneFaultLineOe,
	input wire logic alertLowIn,
	output logic alertLowOut,
	output logic alertLowOe,
	input wire logic inputCutIn,
	output logic inputCutOut,
	output logic inputCutOe,
	output logic [cfm_pkg::NCH-1:0] converterEnOut,
	output logic powerGoodOut,
	output logic [cfm_pkg::NCH*cfm_pkg::DAC_BITS-1:0] trimDacOutCode,
	output logic [cfm_pkg::NCH-1:0] trimDacOutRange,
	output logic [cfm_pkg::NCH-1:0] trimDacOutPol
);
	import cfm_pkg::*;
	logic [31:0] chCfg_ff [NCH];
	logic [15:0] chTon_ff [NCH];
	logic [31:0] chWarn_ff [NCH];
	logic [7:0] oper_ff, cutOv_ff, cutUv_ff, pgMap_ff, devCfg_ff, tickCnt_ff;
	logic [15:0] restartDly_ff, retryDly_ff, persist_ff;
	logic [31:0] vinLim_ff;
	logic [NCH-1:0] ovSt_ff, uvSt_ff, ovWn_ff, uvWn_ff;
	logic [NCH-1:0] ovWnSet, uvWnSet, faultedOff, latched, zoneOff, fwd0, fwd1;
	logic [NCH-1:0] faultNow, faultLater, chanGood;
	logic [3:0] zoneLow, chRel;
	logic [1:0] ctrlQual, ctrlQual_ff, ctrlPrev_ff, restartPulse_ff, ctrlRise_ff;
	logic tick, softRst, wrEn, rdPhase, operWr, clrFaults, chSel;
	logic vinAbove_ff, vinOk_ff, vinRise_ff, sharePrev_ff, cut_ff, vinSample;
	logic [2:0] chIdx;
	logic [1:0] sub;
	logic [31:0] rdData;
	logic rdErr;

	// 1 us tick divider
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			tickCnt_ff <= 8'h00;
		else if (tick)
			tickCnt_ff <= 8'h00;
		else
			tickCnt_ff <= tickCnt_ff + 8'h01;
	end
	assign tick = (tickCnt_ff == 8'(TICK_CYC - 8'h01));

	// reset input qualifier
	cfm_deglitch #(.TICKS(RESET_PULSE_TICKS)) u_rstq (
		.mclk(mclk),
		.rst_n(rst_n),
		.tick(tick),
		.lowIn(!watchdogResetIn),
		.qualLow(softRst)
	);

	// control input qualifiers and restart trigger
	for (genvar c = 0; c < 2; c++) begin : g_ctrl
		cfm_deglitch #(.TICKS(DEGLITCH_TICKS)) u_ctrlq (
			.mclk(mclk),
			.rst_n(rst_n),
			.tick(tick),
			.lowIn(!controlIn[c]),
			.qualLow(ctrlQual[c])
		);
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlQual_ff <= 2'h0;
			ctrlPrev_ff <= 2'h3;
			restartPulse_ff <= 2'h0;
			ctrlRise_ff <= 2'h0;
		end else begin
			ctrlQual_ff <= ctrlQual;
			ctrlPrev_ff <= controlIn;
			restartPulse_ff <= ctrlQual_ff & ~ctrlQual;
			ctrlRise_ff <= controlIn & ~ctrlPrev_ff;
		end
	end

	// zone line readback with deglitch
	for (genvar z = 0; z < 4; z++) begin : g_zone
		cfm_deglitch #(.TICKS(DEGLITCH_TICKS)) u_zoneq (
			.mclk(mclk),
			.rst_n(rst_n),
			.tick(tick),
			.lowIn(!zoneFaultLineIn[z]),
			.qualLow(zoneLow[z])
		);
	end

	// apb slave, one wait state
	assign rdPhase = psel && penable && !pready;
	assign wrEn = psel && penable && pready && pwrite && !pslverr;
	assign chRel = paddr[7:4] - {REG_CH_WINDOW, 2'b00};
	assign chSel = !chRel[3];
	assign chIdx = chRel[2:0];
	assign sub = paddr[3:2];
	assign operWr = wrEn && paddr == REG_OPERATION;
	assign clrFaults = wrEn && paddr == REG_CLEAR_FAULTS;
	always_comb begin
		rdData = 32'h0000_0000;
		rdErr = 1'b0;
		if (chSel) begin
			case (sub)
				REG_CH_CFG: rdData = chCfg_ff[chIdx];
				REG_CH_TON: rdData = {16'h0000, chTon_ff[chIdx]};
				REG_CH_WARN: rdData = chWarn_ff[chIdx];
				default: rdErr = 1'b1;
			endcase
		end else begin
			case (paddr)
				REG_OPERATION: rdData = {24'h000000, oper_ff};
				REG_CLEAR_FAULTS: rdData = 32'h0000_0000;
				REG_STATUS: rdData = {uvWn_ff, ovWn_ff, uvSt_ff, ovSt_ff};
				REG_STATE: rdData = {8'h00, zoneFaultLineIn, powerGoodOut, inputCutIn,
					alertLowIn, vinOk_ff, latched, converterEnOut};
				REG_CUT_OV: rdData = {24'h000000, cutOv_ff};
				REG_CUT_UV: rdData = {24'h000000, cutUv_ff};
				REG_PG_MAP: rdData = {24'h000000, pgMap_ff};
				REG_DEVICE_CFG: rdData = {24'h000000, devCfg_ff};
				REG_RESTART_DLY: rdData = {16'h0000, restartDly_ff};
				REG_RETRY_DLY: rdData = {16'h0000, retryDly_ff};
				REG_PERSIST: rdData = {16'h0000, persist_ff};
				REG_VIN_LIMITS: rdData = vinLim_ff;
				default: rdErr = 1'b1;
			endcase
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= rdPhase;
			prdata <= (rdPhase && !pwrite) ? rdData : 32'h0000_0000;
			pslverr <= rdPhase && rdErr;
		end
	end

	// global registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n || softRst) begin
			oper_ff <= OPER_RST;
			cutOv_ff <= 8'h00;
			cutUv_ff <= 8'h00;
			pgMap_ff <= PG_MAP_RST;
			devCfg_ff <= 8'h00;
			restartDly_ff <= RESTART_RST;
			retryDly_ff <= RETRY_RST;
			persist_ff <= PERSIST_RST;
			vinLim_ff <= VIN_LIM_RST;
		end else if (wrEn && !chSel) begin
			case (paddr)
				REG_OPERATION: oper_ff <= pwdata[7:0];
				REG_CUT_OV: cutOv_ff <= pwdata[7:0];
				REG_CUT_UV: cutUv_ff <= pwdata[7:0];
				REG_PG_MAP: pgMap_ff <= pwdata[7:0];
				REG_DEVICE_CFG: devCfg_ff <= pwdata[7:0];
				REG_RESTART_DLY: restartDly_ff <= pwdata[15:0];
				REG_RETRY_DLY: retryDly_ff <= pwdata[15:0];
				REG_PERSIST: persist_ff <= pwdata[15:0];
				REG_VIN_LIMITS: vinLim_ff <= pwdata;
				default: oper_ff <= oper_ff;
			endcase
		end
	end

	// per-channel registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n || softRst) begin
			for (int i = 0; i < NCH; i++) begin
				chCfg_ff[i] <= CFG_RST;
				chTon_ff[i] <= TON_RST;
				chWarn_ff[i] <= WARN_RST;
			end
		end else if (wrEn && chSel) begin
			case (sub)
				REG_CH_CFG: chCfg_ff[chIdx] <= pwdata;
				REG_CH_TON: chTon_ff[chIdx] <= pwdata[15:0];
				REG_CH_WARN: chWarn_ff[chIdx] <= pwdata;
				default: chTon_ff[chIdx] <= chTon_ff[chIdx];
			endcase
		end
	end

	// input voltage thresholds, optionally paced by the shared timebase
	assign vinSample = adcValid && adcChan == ADC_VIN_CH;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n || softRst) begin
			vinAbove_ff <= 1'b0;
			vinOk_ff <= 1'b0;
			vinRise_ff <= 1'b0;
			sharePrev_ff <= 1'b0;
		end else begin
			sharePrev_ff <= shareClkIn;
			if (vinSample && adcData > vinLim_ff[15:0])
				vinAbove_ff <= 1'b1;
			else if (vinSample && adcData < vinLim_ff[31:16])
				vinAbove_ff <= 1'b0;
			if (!devCfg_ff[DEV_SHARE] || (shareClkIn && !sharePrev_ff))
				vinOk_ff <= vinAbove_ff;
			vinRise_ff <= vinAbove_ff && !vinOk_ff &&
				(!devCfg_ff[DEV_SHARE] || (shareClkIn && !sharePrev_ff));
		end
	end

	// channels
	for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
		localparam int ZB = (ch / 4) * 2;
		logic sel;
		assign sel = chCfg_ff[ch][CFG_CTRL];
		assign faultNow[ch] = (ovFaultIn[ch] && chCfg_ff[ch][CFG_OVR+:2] == RESP_NOW) ||
			(uvFaultIn[ch] && chCfg_ff[ch][CFG_UVR+:2] == RESP_NOW);
		assign faultLater[ch] = (ovFaultIn[ch] && chCfg_ff[ch][CFG_OVR+:2] == RESP_LATER) ||
			(uvFaultIn[ch] && chCfg_ff[ch][CFG_UVR+:2] == RESP_LATER);
		assign zoneOff[ch] = |(chCfg_ff[ch][CFG_LSN+:2] & zoneLow[ZB+:2]);
		assign fwd0[ch] = faultedOff[ch] && chCfg_ff[ch][CFG_FWD];
		assign fwd1[ch] = faultedOff[ch] && chCfg_ff[ch][CFG_FWD+1];
		assign ovWnSet[ch] = adcValid && adcChan == 4'(ch) &&
			adcData > chWarn_ff[ch][15:0];
		assign uvWnSet[ch] = adcValid && adcChan == 4'(ch) &&
			adcData < chWarn_ff[ch][31:16];
		assign chanGood[ch] = converterEnOut[ch] && !ovFaultIn[ch] && !uvFaultIn[ch];
		assign trimDacOutCode[ch*DAC_BITS+:DAC_BITS] = chCfg_ff[ch][CFG_CODE+:DAC_BITS];
		assign trimDacOutRange[ch] = chCfg_ff[ch][CFG_RANGE];
		assign trimDacOutPol[ch] = chCfg_ff[ch][CFG_POL];
		cfm_chan_seq u_seq (
			.mclk(mclk),
			.rst_n(rst_n),
			.softRst(softRst),
			.tick(tick),
			.runReq(vinOk_ff && oper_ff[ch] && controlIn[sel]),
			.restartReq(restartPulse_ff[sel]),
			.clearLatch(operWr || ctrlRise_ff[sel] || vinRise_ff),
			.faultNow(faultNow[ch]),
			.faultLater(faultLater[ch]),
			.zoneOff(zoneOff[ch]),
			.retryEn(chCfg_ff[ch][CFG_RETRY]),
			.tonDelay(chTon_ff[ch]),
			.retryDelay(retryDly_ff),
			.restartDelay(restartDly_ff),
			.persist(persist_ff),
			.convEn(converterEnOut[ch]),
			.faultedOff(faultedOff[ch]),
			.latched(latched[ch])
		);
	end

	// status, alert, input cut-off, zone drive, power good
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n || softRst) begin
			ovSt_ff <= 8'h00;
			uvSt_ff <= 8'h00;
			ovWn_ff <= 8'h00;
			uvWn_ff <= 8'h00;
		end else begin
			ovSt_ff <= (clrFaults ? 8'h00 : ovSt_ff) | ovFaultIn;
			uvSt_ff <= (clrFaults ? 8'h00 : uvSt_ff) | uvFaultIn;
			ovWn_ff <= (clrFaults ? 8'h00 : ovWn_ff) | ovWnSet;
			uvWn_ff <= (clrFaults ? 8'h00 : uvWn_ff) | uvWnSet;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n || softRst)
			cut_ff <= 1'b0;
		else
			cut_ff <= (cut_ff && !operWr) ||
				|((ovFaultIn & cutOv_ff) | (uvFaultIn & cutUv_ff));
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n || softRst) begin
			alertLowOe <= 1'b0;
			alertLowOut <= 1'b1;
			inputCutOe <= 1'b0;
			inputCutOut <= 1'b1;
			zoneFaultLineOe <= 4'h0;
			zoneFaultLineOut <= 4'hf;
			powerGoodOut <= 1'b0;
		end else begin
			alertLowOe <= |{ovSt_ff, uvSt_ff, ovWn_ff, uvWn_ff};
			alertLowOut <= !(|{ovSt_ff, uvSt_ff, ovWn_ff, uvWn_ff});
			inputCutOe <= cut_ff;
			inputCutOut <= !cut_ff;
			for (int z = 0; z < 2; z++) begin
				zoneFaultLineOe[2*z] <= |fwd0[4*z+:4];
				zoneFaultLineOe[2*z+1] <= |fwd1[4*z+:4];
				zoneFaultLineOut[2*z] <= !(|fwd0[4*z+:4]);
				zoneFaultLineOut[2*z+1] <= !(|fwd1[4*z+:4]);
			end
			if (vinSample)
				powerGoodOut <= &(chanGood | ~pgMap_ff);
		end
	end
endmodule : cfm_fault_restart

// ==== verification/cfm_fault_restart_assertions.sv ====
/*
 checker of the fault and restart manager: apb timing, open-drain pins, alert and cut-off.
 assumes binding to cfm_fault_restart and its one mclk domain.
*/
`timescale 1ns/1ps
module cfm_fault_restart_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic watchdogResetIn,
	input wire logic [cfm_pkg::NCH-1:0] ovFaultIn,
	input wire logic [cfm_pkg::NCH-1:0] uvFaultIn,
	input wire logic adcValid,
	input wire logic [3:0] zoneFaultLineOut,
	input wire logic [3:0] zoneFaultLineOe,
	input wire logic alertLowOut,
	input wire logic alertLowOe,
	input wire logic inputCutOut,
	input wire logic inputCutOe
);
	import cfm_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic wrDone;
	assign wrDone = psel && penable && pready && pwrite;
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	ready_wait_a: assert property (pready |-> psel && penable && $past(penable))
		else $error("pready without an access phase");
	slverr_ready_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad pslverr");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
	zone_od_a: assert property (zoneFaultLineOut == ~zoneFaultLineOe) else $error("zone pin drives high");
	alert_od_a: assert property (alertLowOut == !alertLowOe) else $error("alert pin drives high");
	cut_od_a: assert property (inputCutOut == !inputCutOe) else $error("cut pin drives high");
	alert_set_a: assert property ((ovFaultIn != 8'h00) && watchdogResetIn |-> ##[1:3] alertLowOe)
		else $error("fault did not pull alert low");
	alert_clear_a: assert property (wrDone && paddr == REG_CLEAR_FAULTS && ovFaultIn == 8'h00
		&& uvFaultIn == 8'h00 && !adcValid |-> ##[1:3] !alertLowOe) else $error("alert not released");
	cut_release_a: assert property (wrDone && paddr == REG_OPERATION && ovFaultIn == 8'h00
		&& uvFaultIn == 8'h00 |-> ##[1:4] !inputCutOe) else $error("cut-off not released");
endmodule : cfm_fault_restart_checker

bind cfm_fault_restart cfm_fault_restart_checker cfm_fault_restart_checker_inst (.mclk(mclk),
	.rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdogResetIn(watchdogResetIn),
	.ovFaultIn(ovFaultIn), .uvFaultIn(uvFaultIn), .adcValid(adcValid),
	.zoneFaultLineOut(zoneFaultLineOut), .zoneFaultLineOe(zoneFaultLineOe),
	.alertLowOut(alertLowOut), .alertLowOe(alertLowOe), .inputCutOut(inputCutOut),
	.inputCutOe(inputCutOe));

// ==== verification/cfm_far_side_model.sv ====
/*
 far side model: converters, adc sweep, peer manager on the zone lines, pull-ups.
 assumes the bench commands faults, input voltage and peer pulls.
*/
`timescale 1ns/1ps
module cfm_far_side_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] zoneOe,
	input wire logic [3:0] peerPull,
	input wire logic alertOe,
	input wire logic cutOe,
	input wire logic [7:0] enIn,
	input wire logic [7:0] injOv,
	input wire logic [15:0] vinLevel,
	output logic [3:0] zoneLines,
	output logic alertLine,
	output logic cutLine,
	output logic [7:0] ovOut,
	output logic adcValid,
	output logic [3:0] adcChan,
	output logic [15:0] adcData
);
	logic [3:0] slot_ff;
	logic [3:0] sweep_ff;
	assign zoneLines = ~(zoneOe | peerPull);
	assign alertLine = ~alertOe;
	assign cutLine = ~cutOe;
	assign ovOut = injOv & enIn;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			slot_ff <= 4'h0;
			sweep_ff <= 4'h0;
			adcValid <= 1'b0;
			adcChan <= 4'h0;
			adcData <= 16'h0000;
		end else begin
			slot_ff <= slot_ff + 4'h1;
			adcValid <= slot_ff == 4'hf;
			if (slot_ff == 4'hf) begin
				adcChan <= sweep_ff;
				adcData <= (sweep_ff == 4'h8) ? vinLevel : 16'h8000;
				sweep_ff <= (sweep_ff == 4'h8) ? 4'h0 : sweep_ff + 4'h1;
			end else begin
				adcData <= ~adcData;
			end
		end
	end
endmodule : cfm_far_side_model

// ==== verification/cfm_fault_restart_tb.sv ====
/*
 testbench of the fault and restart manager: apb tasks and scenario sequence.
 assumes cfm_far_side_model on the pins and a 250 MHz mclk.
*/
`timescale 1ns/1ps
module cfm_fault_restart_tb;
	import cfm_pkg::*;
	logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, wdog, pg, aOe, cOe, aLine, cLine;
	logic [7:0] paddr, en, injOv, ov, uv, dacRange, dacPol;
	logic [79:0] dacCode;
	logic [31:0] pwdata, prdata, rdv;
	logic [1:0] ctl;
	logic [3:0] zOe, zLines, peer, aChan;
	logic [15:0] vin, aData;
	logic aValid, share;
	int n_fail, checks, cyc;
	cfm_fault_restart cfm_fault_restart_inst (.mclk(mclk), .rst_n(rst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .controlIn(ctl), .watchdogResetIn(wdog),
		.ovFaultIn(ov), .uvFaultIn(uv), .adcValid(aValid), .adcChan(aChan), .adcData(aData),
		.shareClkIn(share), .zoneFaultLineIn(zLines), .zoneFaultLineOut(), .zoneFaultLineOe(zOe),
		.alertLowIn(aLine), .alertLowOut(), .alertLowOe(aOe), .inputCutIn(cLine),
		.inputCutOut(), .inputCutOe(cOe), .converterEnOut(en), .powerGoodOut(pg),
		.trimDacOutCode(dacCode), .trimDacOutRange(dacRange), .trimDacOutPol(dacPol));
	cfm_far_side_model cfm_far_side_model_inst (.mclk(mclk), .rst_n(rst_n), .zoneOe(zOe),
		.peerPull(peer), .alertOe(aOe), .cutOe(cOe), .enIn(en), .injOv(injOv), .vinLevel(vin),
		.zoneLines(zLines), .alertLine(aLine), .cutLine(cLine), .ovOut(ov), .adcValid(aValid),
		.adcChan(aChan), .adcData(aData));
	always #2 mclk = ~mclk;
	task automatic complete_run;
		if (n_fail == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 100000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdv = prdata;
		if (a == 8'hfc) cmp("pslverr", 32'h1, 32'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp($sformatf("register %h", a), e, rdv);
	endtask : chk
	task automatic wt(input logic [7:0] m, input logic [7:0] e);
		for (int i = 0; i < 20000 && (en & m) !== e; i++) @(posedge mclk);
		cmp("converter enables", 32'(e), 32'(en & m));
	endtask : wt
	initial begin
		{mclk, rst_n, psel, penable, pwrite, paddr, pwdata, peer, injOv, uv, share} = '0;
		{wdog, ctl, vin} = {1'b1, 2'b11, 16'h4000};
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		chk(REG_OPERATION, 32'(OPER_RST));
		chk(REG_PG_MAP, 32'(PG_MAP_RST));
		chk(8'h40, CFG_RST);
		chk(8'h44, 32'(TON_RST));
		chk(8'hfc, 32'h0);
		apb(1'b1, REG_VIN_LIMITS, 32'h0800_1000);
		wt(8'hff, 8'hff);
		for (int i = 0; i < 2000 && pg !== 1'b1; i++) @(posedge mclk);
		cmp("power good", 32'h1, 32'(pg));
		vin <= 16'h0400;
		wt(8'hff, 8'h00);
		vin <= 16'h4000;
		wt(8'hff, 8'hff);
		apb(1'b1, REG_DEVICE_CFG, 32'h1);
		vin <= 16'h0400;
		repeat (600) @(posedge mclk);
		cmp("share holds", 32'hff, 32'(en));
		share <= 1'b1;
		wt(8'hff, 8'h00);
		share <= 1'b0;
		vin <= 16'h4000;
		apb(1'b1, REG_DEVICE_CFG, 32'h0);
		wt(8'hff, 8'hff);
		apb(1'b1, REG_CUT_OV, 32'h1);
		apb(1'b1, 8'h40, 32'h128);
		injOv <= 8'h01;
		repeat (4) @(posedge mclk);
		cmp("immediate off", 32'h0, 32'(en[0]));
		injOv <= 8'h00;
		chk(REG_STATUS, 32'h1);
		cmp("pins", 32'h0, {aLine, cLine, zLines[0]});
		apb(1'b0, REG_STATE, 32'h0);
		cmp("latched", 32'h1, 32'(rdv[15:8]));
		apb(1'b1, REG_OPERATION, 32'hff);
		repeat (4) @(posedge mclk);
		cmp("cut released", 32'h1, 32'(cLine));
		wt(8'h01, 8'h01);
		apb(1'b1, REG_CLEAR_FAULTS, 32'h0);
		chk(REG_STATUS, 32'h0);
		cmp("alert released", 32'h1, 32'(aLine));
		apb(1'b1, 8'h50, 32'ha8);
		apb(1'b1, 8'h60, 32'h20);
		apb(1'b1, REG_RETRY_DLY, 32'h5);
		injOv <= 8'h06;
		repeat (500) @(posedge mclk);
		cmp("ignore stays on", 32'h1, 32'(en[2]));
		injOv <= 8'h00;
		wt(8'h02, 8'h02);
		chk(REG_STATUS, 32'h6);
		apb(1'b1, REG_CLEAR_FAULTS, 32'h0);
		apb(1'b1, 8'h50, 32'h1028);
		peer <= 4'h1;
		repeat (1250) @(posedge mclk);
		cmp("deglitch", 32'h1, 32'(en[1]));
		repeat (2500) @(posedge mclk);
		cmp("zone off", 32'h0, 32'(en[1]));
		peer <= 4'h0;
		wt(8'h02, 8'h02);
		apb(1'b1, 8'hb0, 32'h2c);
		apb(1'b1, REG_RESTART_DLY, 32'd20);
		ctl <= 2'b10;
		repeat (3750) @(posedge mclk);
		cmp("mapped off", 32'h80, 32'(en));
		ctl <= 2'b11;
		repeat (2500) @(posedge mclk);
		cmp("restart hold", 32'h80, 32'(en));
		wt(8'hff, 8'hff);
		apb(1'b1, REG_PERSIST, 32'h4);
		apb(1'b1, 8'h70, 32'h0155_00c3);
		uv <= 8'h08;
		repeat (500) @(posedge mclk);
		cmp("persist wait", 32'h1, 32'(en[3]));
		cmp("dac fields", 32'h557, 32'({dacCode[39:30], dacRange[3], dacPol[3]}));
		wt(8'h08, 8'h00);
		uv <= 8'h00;
		chk(REG_STATUS, 32'h0000_0800);
		wdog <= 1'b0;
		repeat (3000) @(posedge mclk);
		wdog <= 1'b1;
		repeat (4) @(posedge mclk);
		chk(REG_RETRY_DLY, 32'(RETRY_RST));
		chk(8'h40, CFG_RST);
		complete_run();
	end
endmodule : cfm_fault_restart_tb
